//--- core/stm16_pkg.sv
// stm16_pkg: register map, field layout, reset values and clock selections of the 16-bit standard timer
// assumes a byte-wide register port and one 50 MHz system clock
//
// Functional notes
// [R01] counter is 16 bits wide and only counts up on each selected clock tick
// [R02] compare P holds 8 bits and matches the counter's top byte
// [R03] compare A holds 16 bits and matches only the full count
// [R04] software cannot write the count; its only software clear is a run-enable rising edge
// [R05] counter clears on overflow or on a match from the selected comparator
// [R06] count is read through low and high read-only bytes; writes are ignored
// [R07] pause bit holds the count; clearing it resumes from the held value
// [R08] clock select picks sys/4, sys, high/16, high/64, sub, or external rising/falling edge
// [R09] instance zero has no external clock pin; edge selections are unavailable there
// [R10] run-enable low stops counting; rising edge clears count; falling edge keeps it
// [R11] run-enable rising edge restores output pin to its initial level in output modes
// [R12] mode field: 00 compare output, 01 capture, 10 pwm or single pulse, 11 timer
// [R13] software turns the timer off before changing the mode field
// [R14] output pin level is undefined in timer/counter mode
// [R15] control 0 bits 2 to 0 always read zero and ignore writes
// [R16] compare low byte write loads a buffer; high byte write transfers it
// [R17] high byte read copies paired low byte into the buffer; low read returns buffer
// [R18] compare P zero gives 65536 clock period; 1 to 255 gives value times 256
// [R19] clear source bit 1 clears on compare A; 0 on compare P or overflow
// [R20] each comparator match raises its own single-cycle request flag; the core flags compare A only when nonzero, compare P only as clear source

package stm16_pkg;

  // ********************************************************
  // register offsets
  // ********************************************************
  localparam logic [2:0] STM16_OFS_CTRL0 = 3'h0;
  localparam logic [2:0] STM16_OFS_CTRL1 = 3'h1;
  localparam logic [2:0] STM16_OFS_CNT_LO = 3'h2;
  localparam logic [2:0] STM16_OFS_CNT_HI = 3'h3;
  localparam logic [2:0] STM16_OFS_CMPA_LO = 3'h4;
  localparam logic [2:0] STM16_OFS_CMPA_HI = 3'h5;
  localparam logic [2:0] STM16_OFS_CMPP = 3'h6;

  // ********************************************************
  // field positions and reset values
  // ********************************************************
  localparam int STM16_C0_PAUSE = 7;
  localparam int STM16_C0_CKSEL_LSB = 4;
  localparam int STM16_C0_RUN = 3;
  localparam logic [7:0] STM16_C0_IMPL_MASK = 8'hF8;
  localparam int STM16_C1_MODE_LSB = 6;
  localparam int STM16_C1_INIT_LVL = 3;
  localparam int STM16_C1_CLR_SRC = 0;
  localparam logic [7:0] STM16_RESET_BYTE = 8'h00;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int STM16_SYS_CLK_HZ = 50000000;
  localparam int STM16_HIGH_DIV = 16;
  localparam int STM16_HIGH_DIV2 = 64;
  localparam int STM16_SYS_DIV = 4;
  localparam int STM16_DIV_W = 6;

  typedef enum logic [2:0] {
    STM16_CK_SYS4, STM16_CK_SYS, STM16_CK_HI16, STM16_CK_HI64,
    STM16_CK_SUB0, STM16_CK_SUB1, STM16_CK_EXT_RISE, STM16_CK_EXT_FALL
  } stm16_cksel_e;

  typedef enum logic [1:0] {
    STM16_MODE_CMP_OUT, STM16_MODE_CAPTURE, STM16_MODE_PWM, STM16_MODE_TIMER
  } stm16_mode_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stm16_bus_s;

  typedef struct packed {
    logic match_a;
    logic match_p;
    logic overflow;
  } stm16_event_s;

endpackage : stm16_pkg

//--- core/stm16_tick_gen.sv
// stm16_tick_gen: builds the one-cycle count enable from the selected clock source
// assumes sub-clock and external pin inputs are synchronous to clk_in
`timescale 1ns/1ps
module stm16_tick_gen #(
  parameter bit HAS_EXT_PIN = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] sel_in,
  input wire logic high_tick_in,
  input wire logic sub_tick_in,
  input wire logic ext_pin_in,
  output logic tick_out
);

  logic [stm16_pkg::STM16_DIV_W-1:0] div_cnt;
  logic [stm16_pkg::STM16_DIV_W-1:0] high_cnt;
  logic ext_prev;
  logic next_tick;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      high_cnt <= '0;
    end else if (high_tick_in) begin
      high_cnt <= high_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_pin_in;
    end
  end

  always_comb begin
    next_tick = 1'b0;
    unique case (stm16_pkg::stm16_cksel_e'(sel_in)) // [R08]
      stm16_pkg::STM16_CK_SYS4: next_tick = (div_cnt[1:0] == 2'h3);
      stm16_pkg::STM16_CK_SYS: next_tick = 1'b1;
      stm16_pkg::STM16_CK_HI16: next_tick = high_tick_in && (high_cnt[3:0] == 4'hF);
      stm16_pkg::STM16_CK_HI64: next_tick = high_tick_in && (high_cnt == 6'h3F);
      stm16_pkg::STM16_CK_SUB0, stm16_pkg::STM16_CK_SUB1: next_tick = sub_tick_in;
      stm16_pkg::STM16_CK_EXT_RISE: next_tick = HAS_EXT_PIN && ext_pin_in && !ext_prev; // [R09]
      stm16_pkg::STM16_CK_EXT_FALL: next_tick = HAS_EXT_PIN && !ext_pin_in && ext_prev; // [R09]
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= next_tick;
    end
  end

endmodule : stm16_tick_gen

//--- core/stm16_timer.sv
// stm16_timer: 16-bit standard timer core with compare A / compare P and byte register port
// assumes one clock, synchronous reset, and a master that never issues read and write together
`timescale 1ns/1ps
module stm16_timer #(
  parameter bit HAS_EXT_PIN = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic high_tick_in,
  input wire logic sub_tick_in,
  input wire logic ext_clock_pin_in,
  output logic timer_out,
  output logic match_a_out,
  output logic match_p_out,
  output logic running_out
);

  // ********************************************************
  // registers
  // ********************************************************
  stm16_pkg::stm16_bus_s bus;
  logic [7:0] timer_control_0;
  logic [7:0] timer_control_1;
  logic [15:0] compare_a_value;
  logic [7:0] compare_p_value;
  logic [7:0] hold_buf;
  logic [15:0] count;
  logic run_prev;
  logic tick;
  stm16_pkg::stm16_event_s ev;
  logic run_en;
  logic pause;
  logic run_rise;
  logic count_en;
  logic clr_src;
  logic [1:0] mode;
  logic [7:0] next_rdata;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign run_en = timer_control_0[stm16_pkg::STM16_C0_RUN];
  assign pause = timer_control_0[stm16_pkg::STM16_C0_PAUSE];
  assign clr_src = timer_control_1[stm16_pkg::STM16_C1_CLR_SRC];
  assign mode = timer_control_1[stm16_pkg::STM16_C1_MODE_LSB +: 2];
  assign run_rise = run_en && !run_prev;
  assign count_en = run_en && !pause && tick && !run_rise;

  stm16_tick_gen #(.HAS_EXT_PIN(HAS_EXT_PIN)) u_tick (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .sel_in(timer_control_0[stm16_pkg::STM16_C0_CKSEL_LSB +: 3]),
    .high_tick_in(high_tick_in),
    .sub_tick_in(sub_tick_in),
    .ext_pin_in(ext_clock_pin_in),
    .tick_out(tick)
  );

  // ********************************************************
  // control registers
  // ********************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer_control_0 <= stm16_pkg::STM16_RESET_BYTE;
      timer_control_1 <= stm16_pkg::STM16_RESET_BYTE;
      compare_p_value <= stm16_pkg::STM16_RESET_BYTE;
    end else if (bus.wr) begin
      if (bus.addr == stm16_pkg::STM16_OFS_CTRL0) begin
        timer_control_0 <= bus.wdata & stm16_pkg::STM16_C0_IMPL_MASK; // [R15]
      end
      if (bus.addr == stm16_pkg::STM16_OFS_CTRL1) begin
        timer_control_1 <= bus.wdata; // [R12]
      end
      if (bus.addr == stm16_pkg::STM16_OFS_CMPP) begin
        compare_p_value <= bus.wdata;
      end
    end
  end

  // buffered compare A and shared holding buffer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      compare_a_value <= '0;
      hold_buf <= stm16_pkg::STM16_RESET_BYTE;
    end else if (bus.wr && bus.addr == stm16_pkg::STM16_OFS_CMPA_LO) begin
      hold_buf <= bus.wdata; // [R16]
    end else if (bus.wr && bus.addr == stm16_pkg::STM16_OFS_CMPA_HI) begin
      compare_a_value <= {bus.wdata, hold_buf}; // [R16]
    end else if (bus.rd && bus.addr == stm16_pkg::STM16_OFS_CNT_HI) begin
      hold_buf <= count[7:0]; // [R17]
    end else if (bus.rd && bus.addr == stm16_pkg::STM16_OFS_CMPA_HI) begin
      hold_buf <= compare_a_value[7:0]; // [R17]
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= run_en;
    end
  end

  // ********************************************************
  // counter and comparators
  // ********************************************************
  always_comb begin
    ev.match_a = count_en && (count == compare_a_value); // [R03]
    // p match is taken on the last count below the compared top byte, so the period is the value times 256
    ev.match_p = count_en && (count[15:8] == 8'(compare_p_value - 8'h01)) && (compare_p_value != 8'h00); // [R02]
    ev.overflow = count_en && (count == 16'hFFFF);
  end

  // match is checked on the tick that would advance past the compared value
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count <= '0;
    end else if (run_rise) begin
      count <= '0; // [R04] [R10]
    end else if (count_en) begin // [R07]
      if (clr_src && ev.match_a) begin
        count <= '0; // [R19] [R05]
      end else if (!clr_src && ev.match_p && (count[7:0] == 8'hFF)) begin
        count <= '0; // [R18] [R19] [R05]
      end else begin
        count <= count + 16'h0001; // [R01] [R18]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      match_a_out <= 1'b0;
      match_p_out <= 1'b0;
    end else begin
      match_a_out <= ev.match_a && (compare_a_value != 16'h0000); // [R20]
      match_p_out <= ev.match_p && !clr_src && (count[7:0] == 8'hFF); // [R20]
    end
  end

  // ********************************************************
  // output pin
  // ********************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer_out <= 1'b0;
    end else if (run_rise && mode != 2'(stm16_pkg::STM16_MODE_CAPTURE)
                 && mode != 2'(stm16_pkg::STM16_MODE_TIMER)) begin
      timer_out <= timer_control_1[stm16_pkg::STM16_C1_INIT_LVL]; // [R11]
    end else if (mode == 2'(stm16_pkg::STM16_MODE_TIMER)) begin
      timer_out <= 1'b0; // [R14]
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      running_out <= 1'b0;
    end else begin
      running_out <= run_en && !pause;
    end
  end

  // ********************************************************
  // read port
  // ********************************************************
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        stm16_pkg::STM16_OFS_CTRL0: next_rdata = timer_control_0 & stm16_pkg::STM16_C0_IMPL_MASK; // [R15]
        stm16_pkg::STM16_OFS_CTRL1: next_rdata = timer_control_1;
        stm16_pkg::STM16_OFS_CNT_LO: next_rdata = hold_buf; // [R06] [R17]
        stm16_pkg::STM16_OFS_CNT_HI: next_rdata = count[15:8]; // [R06]
        stm16_pkg::STM16_OFS_CMPA_LO: next_rdata = hold_buf; // [R17]
        stm16_pkg::STM16_OFS_CMPA_HI: next_rdata = compare_a_value[15:8];
        stm16_pkg::STM16_OFS_CMPP: next_rdata = compare_p_value;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  sequence s_run_rise;
    run_en && !run_prev;
  endsequence

  AST_RISE_CLEARS: assert property (@(posedge clk_in) disable iff (reset_in) // [R10]
    s_run_rise |=> count == 16'h0000) else $error("run rising edge did not clear count");
  AST_STOP_HOLDS: assert property (@(posedge clk_in) disable iff (reset_in) // [R10]
    !run_en && !run_rise |=> $stable(count)) else $error("count moved while off");
  AST_PAUSE_HOLDS: assert property (@(posedge clk_in) disable iff (reset_in) // [R07]
    pause && !run_rise |=> $stable(count)) else $error("count moved while paused");
  AST_COUNT_UP: assert property (@(posedge clk_in) disable iff (reset_in) // [R01]
    count_en && !ev.match_a && !ev.match_p && count != 16'hFFFF |=> count == $past(count) + 16'h0001)
    else $error("count did not advance by one");
  AST_A_CLEAR: assert property (@(posedge clk_in) disable iff (reset_in) // [R19]
    count_en && clr_src && ev.match_a |=> count == 16'h0000) else $error("compare A match did not clear");
  AST_OVF_WRAP: assert property (@(posedge clk_in) disable iff (reset_in) // [R05]
    count_en && count == 16'hFFFF |=> count == 16'h0000) else $error("overflow did not clear");
  AST_C0_LOW_ZERO: assert property (@(posedge clk_in) disable iff (reset_in) // [R15]
    timer_control_0[2:0] == 3'h0) else $error("unimplemented control bits set");
  AST_CMPA_PAIR: assert property (@(posedge clk_in) disable iff (reset_in) // [R16]
    bus.wr && bus.addr == stm16_pkg::STM16_OFS_CMPA_HI |=> compare_a_value == {$past(bus.wdata), $past(hold_buf)})
    else $error("compare A high write did not transfer buffer");
  AST_INIT_LEVEL: assert property (@(posedge clk_in) disable iff (reset_in) // [R11]
    (s_run_rise and (mode == 2'(stm16_pkg::STM16_MODE_CMP_OUT)))
    |=> timer_out == $past(timer_control_1[stm16_pkg::STM16_C1_INIT_LVL]))
    else $error("output not restored to initial level");
  AST_CAPTURE_KEEPS: assert property (@(posedge clk_in) disable iff (reset_in) // [R11]
    (s_run_rise and (mode == 2'(stm16_pkg::STM16_MODE_CAPTURE))) |=> $stable(timer_out))
    else $error("output moved on run edge in capture mode");
  AST_TIMER_MODE_LOW: assert property (@(posedge clk_in) disable iff (reset_in) // [R14]
    mode == 2'(stm16_pkg::STM16_MODE_TIMER) |=> !timer_out) else $error("output not low in timer mode");
  AST_MATCH_PULSE: assert property (@(posedge clk_in) disable iff (reset_in) // [R20]
    match_a_out |=> !match_a_out) else $error("match A request not single");
  AST_MATCH_P_PULSE: assert property (@(posedge clk_in) disable iff (reset_in) // [R20]
    match_p_out |=> !match_p_out) else $error("match P request not single");
  AST_P_CLEAR: assert property (@(posedge clk_in) disable iff (reset_in) // [R18] [R19]
    count_en && !clr_src && ev.match_p && count[7:0] == 8'hFF |=> count == 16'h0000)
    else $error("compare P match did not clear");
  AST_CNT_HI_READ: assert property (@(posedge clk_in) disable iff (reset_in) // [R06] [R17]
    bus.rd && bus.addr == stm16_pkg::STM16_OFS_CNT_HI
    |=> rdata_out == $past(count[15:8]) && hold_buf == $past(count[7:0]))
    else $error("count high read did not latch low byte");
  AST_RDATA_IDLE: assert property (@(posedge clk_in) disable iff (reset_in) // [R06]
    !bus.rd |=> rdata_out == 8'h00) else $error("read data not cleared after read");
  AST_RUNNING_LEVEL: assert property (@(posedge clk_in) disable iff (reset_in) // [R07] [R10]
    running_out == $past(run_en && !pause)) else $error("running flag wrong");

endmodule : stm16_timer

//--- tb/stm16_timer_tb_top.sv
// stm16_timer_tb_top: self-checking bench for the 16-bit standard timer
// assumes core/stm16_pkg.sv and the core modules are compiled before this file
`timescale 1ns/1ps
module stm16_timer_tb_top;
  // ********************************************************
  // signals and bookkeeping
  // ********************************************************
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic high_tick_in = 1'b0;
  logic sub_tick_in = 1'b0;
  logic ext_clock_pin_in = 1'b0;
  logic [7:0] rdata_out;
  logic timer_out, match_a_out, match_p_out, running_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int last_cyc = 0;
  bit have_last = 1'b0;
  bit ev_sel = 1'b0;
  bit rd_pend = 1'b0;
  logic [7:0] rd_q[$];
  int span_q[$];
  // clock cycles per count for each clock selection, given the tick patterns below
  int span_tab[8] = '{4, 1, 32, 128, 3, 3, 10, 10};

  stm16_timer i_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .high_tick_in(high_tick_in),
    .sub_tick_in(sub_tick_in), .ext_clock_pin_in(ext_clock_pin_in), .timer_out(timer_out),
    .match_a_out(match_a_out), .match_p_out(match_p_out), .running_out(running_out));

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  // high tick every 2 cycles, sub tick every 3, external pin period 10
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    high_tick_in <= (cyc % 2 == 0);
    sub_tick_in <= (cyc % 3 == 0);
    ext_clock_pin_in <= ((cyc / 5) % 2 == 1);
  end

  // ********************************************************
  // compare tasks and output watcher
  // ********************************************************
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_span(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      n_mismatch++;
      $display("wrong value at %0t: match spacing %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_span

  always @(posedge clk_in) begin
    rd_pend <= rd_in;
    if (rd_pend && rd_q.size() > 0) cmp_byte(rdata_out, rd_q.pop_front());
    if (ev_sel ? match_p_out : match_a_out) begin
      if (have_last && span_q.size() > 0) cmp_span(cyc - last_cyc, span_q.pop_front());
      have_last = 1'b1;
      last_cyc = cyc;
    end
  end

  // ********************************************************
  // bus and sequence tasks
  // ********************************************************
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    rd_q.push_back(exp);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : reg_rd

  task automatic wait_span();
    for (int n = 0; n < 3000 && span_q.size() > 0; n++) @(posedge clk_in);
    if (span_q.size() > 0) begin
      n_mismatch++;
      $display("wrong value at %0t: match pulse missing", $time);
      span_q.delete();
    end
  endtask : wait_span

  task automatic run_span(input logic [2:0] ck, input logic [15:0] a, input logic [7:0] p, input logic use_p,
                          input int exp);
    reg_wr(3'h0, 8'h00);
    reg_wr(3'h1, {2'h3, 5'h00, ~use_p});
    reg_wr(3'h4, a[7:0]);
    reg_wr(3'h5, a[15:8]);
    reg_wr(3'h6, p);
    ev_sel = use_p;
    have_last = 1'b0;
    span_q.push_back(exp);
    reg_wr(3'h0, {1'b0, ck, 4'h8});
    wait_span();
  endtask : run_span

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end

  // ********************************************************
  // tests
  // ********************************************************
  initial begin
    logic [15:0] a;
    logic [7:0] v;
    void'($urandom(99));
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int r = 0; r < 8; r++) reg_rd(r[2:0], 8'h00);
    reg_wr(3'h0, 8'h87);
    reg_rd(3'h0, 8'h80);
    reg_wr(3'h7, 8'hFF);
    reg_rd(3'h7, 8'h00);
    for (int m = 0; m < 4; m++) begin
      v = {m[1:0], 6'($urandom())};
      reg_wr(3'h1, v);
      reg_rd(3'h1, v);
      a = 16'($urandom());
      reg_wr(3'h4, a[7:0]);
      reg_wr(3'h5, a[15:8]);
      reg_rd(3'h5, a[15:8]);
      reg_rd(3'h4, a[7:0]);
    end
    reg_wr(3'h4, ~a[7:0]);
    reg_rd(3'h5, a[15:8]);
    reg_rd(3'h4, a[7:0]);
    $display("test registers done");
    for (int k = 0; k < 8; k++) run_span(k[2:0], 16'h0003, 8'h00, 1'b0, span_tab[k] * 4);
    run_span(3'h1, 16'h0000, 8'h01, 1'b1, 256);
    $display("test clock and compare done");
    run_span(3'h1, 16'h0009, 8'h00, 1'b0, 10);
    have_last = 1'b0;
    for (int n = 0; n < 100 && !have_last; n++) @(posedge clk_in);
    span_q.push_back(17);
    reg_wr(3'h0, 8'h98);
    repeat (2) @(posedge clk_in);
    #1 cmp_byte({7'h00, running_out}, 8'h00);
    repeat (3) @(posedge clk_in);
    reg_wr(3'h0, 8'h18);
    wait_span();
    $display("test pause done");
    reg_wr(3'h4, 8'h00);
    reg_wr(3'h5, 8'h01);
    repeat (20) @(posedge clk_in);
    reg_wr(3'h0, 8'h00);
    reg_wr(3'h1, 8'h08);
    reg_wr(3'h0, 8'h98);
    reg_wr(3'h2, 8'hFF);
    reg_wr(3'h3, 8'hFF);
    reg_rd(3'h3, 8'h00);
    reg_rd(3'h2, 8'h00);
    #1 cmp_byte({7'h00, timer_out}, 8'h01);
    reg_wr(3'h0, 8'h00);
    reg_wr(3'h1, 8'h00);
    reg_wr(3'h0, 8'h98);
    repeat (2) @(posedge clk_in);
    #1 cmp_byte({7'h00, timer_out}, 8'h00);
    reg_wr(3'h0, 8'h00);
    reg_wr(3'h1, 8'h88);
    reg_wr(3'h0, 8'h98);
    repeat (2) @(posedge clk_in);
    #1 cmp_byte({7'h00, timer_out}, 8'h01);
    reg_wr(3'h0, 8'h00);
    reg_wr(3'h1, 8'h40);
    reg_wr(3'h0, 8'h98);
    repeat (2) @(posedge clk_in);
    #1 cmp_byte({7'h00, timer_out}, 8'h01);
    reg_wr(3'h0, 8'h18);
    repeat (2) @(posedge clk_in);
    #1 cmp_byte({7'h00, running_out}, 8'h01);
    reg_wr(3'h0, 8'h10);
    repeat (2) @(posedge clk_in);
    #1 cmp_byte({7'h00, running_out}, 8'h00);
    $display("test run enable done");
    repeat (4) @(posedge clk_in);
    report_and_stop();
  end
endmodule : stm16_timer_tb_top
